/* File: src/twi_host.sv */
// master end: queued bytes sent as a write, or pointer write then read
`timescale 1ns/1ps
module twi_host (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // command: go pulse, target, pointer, read length (0 means write)
    input wire logic cmd_go,
    input wire logic [6:0] cmd_dev,
    input wire logic [7:0] cmd_ptr,
    input wire logic [7:0] cmd_rd_len,
    output logic cmd_busy,
    output logic cmd_nack,
    // write data stream
    input wire logic wd_valid,
    output logic wd_ready,
    input wire logic [7:0] wd_data,
    // read data
    output logic rd_valid,
    output logic [7:0] rd_data,
    // link
    twi_link_if.host link
);
    import twi_pkg::*;

    logic fv, fr;
    logic [7:0] fd;
    master_state_t st_reg, st_next;
    logic [7:0] div_reg, div_next, sh_reg, sh_next, left_reg, left_next;
    logic [1:0] ph_reg, ph_next, step_reg, step_next;
    logic [3:0] bit_reg, bit_next;
    logic scl_reg, scl_next, sda_reg, sda_next, nack_reg, nack_next;
    logic rv_reg, rv_next, rx_reg, rx_next, sda_m, sda_s, tick;
    logic [7:0] rd_reg, rd_next;

    byte_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .mclk(mclk), .rstn(rstn),
        .in_valid(wd_valid), .in_ready(wd_ready), .in_data(wd_data),
        .out_valid(fv), .out_ready(fr), .out_data(fd)
    );

    // sample sda back through two flops
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sda_m <= 1'b1;
            sda_s <= 1'b1;
        end else begin
            sda_m <= link.sda;
            sda_s <= sda_m;
        end
    end

    // divider makes quarter-bit ticks; step: 0 addr,1 ptr,2 data,3 raddr
    always_comb begin
        st_next = st_reg;
        div_next = (div_reg == HALF_CYC_W) ? 8'h00 : 8'(div_reg + 1'b1);
        tick = (div_reg == HALF_CYC_W);
        ph_next = ph_reg;
        sh_next = sh_reg;
        bit_next = bit_reg;
        step_next = step_reg;
        left_next = left_reg;
        scl_next = scl_reg;
        sda_next = sda_reg;
        nack_next = nack_reg;
        rv_next = 1'b0;
        rx_next = rx_reg;
        rd_next = rd_reg;
        fr = 1'b0;
        case (st_reg)
            M_IDLE: begin
                if (cmd_go) begin
                    st_next = M_START;
                    nack_next = 1'b0;
                    left_next = cmd_rd_len;
                    step_next = 2'h0;
                    ph_next = 2'h0;
                    sh_next = {cmd_dev, 1'b0};
                end
            end
            M_START, M_RSTART: begin
                if (tick) begin
                    ph_next = 2'(ph_reg + 1'b1);
                    case (ph_reg)
                        2'h0: begin
                            sda_next = 1'b1;
                            scl_next = 1'b1;
                        end
                        2'h1: sda_next = 1'b0;
                        2'h2: scl_next = 1'b0;
                        default: begin
                            st_next = M_BIT;
                            bit_next = '0;
                            sda_next = sh_reg[7];
                            ph_next = 2'h0;
                        end
                    endcase
                end
            end
            M_BIT, M_ACK: begin
                if (tick) begin
                    ph_next = 2'(ph_reg + 1'b1);
                    if (ph_reg == 2'h0) begin
                        scl_next = 1'b1;
                    end else if (ph_reg == 2'h1) begin
                        rx_next = sda_s;
                    end else if (ph_reg == 2'h2) begin
                        scl_next = 1'b0;
                    end else if (st_reg == M_BIT) begin
                        sh_next = {sh_reg[6:0], rx_reg};
                        bit_next = 4'(bit_reg + 1'b1);
                        if (bit_reg == 4'h7) begin
                            st_next = M_ACK;
                            // receiving: ack unless last byte
                            sda_next = (step_reg == 2'h2 && left_reg != 8'h00)
                                ? (left_reg == 8'h01) : 1'b1;
                        end else begin
                            sda_next = (step_reg == 2'h2 && left_reg != 8'h00)
                                ? 1'b1 : sh_reg[6];
                        end
                    end else begin
                        st_next = M_BIT;
                        bit_next = '0;
                        if (step_reg == 2'h2 && left_reg != 8'h00) begin
                            rd_next = sh_reg;
                            rv_next = 1'b1;
                            left_next = 8'(left_reg - 1'b1);
                            sda_next = 1'b1;
                            if (left_reg == 8'h01) st_next = M_STOP;
                        end else if (rx_reg) begin
                            nack_next = 1'b1;
                            st_next = M_STOP;
                            sda_next = 1'b0;
                        end else if (step_reg == 2'h0) begin
                            step_next = 2'h1;
                            sh_next = cmd_ptr;
                            sda_next = cmd_ptr[7];
                        end else if (step_reg == 2'h3) begin
                            step_next = 2'h2;
                            sda_next = 1'b1;
                        end else if (left_reg != 8'h00) begin
                            st_next = M_RSTART;
                            step_next = 2'h3;
                            sh_next = {cmd_dev, 1'b1};
                        end else if (fv) begin
                            fr = 1'b1;
                            step_next = 2'h2;
                            sh_next = fd;
                            sda_next = fd[7];
                        end else begin
                            st_next = M_STOP;
                            sda_next = 1'b0;
                        end
                    end
                end
            end
            M_STOP: begin
                if (tick) begin
                    ph_next = 2'(ph_reg + 1'b1);
                    case (ph_reg)
                        2'h0: sda_next = 1'b0;
                        2'h1: scl_next = 1'b1;
                        2'h2: sda_next = 1'b1;
                        default: st_next = M_DONE;
                    endcase
                end
            end
            default: st_next = M_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= M_IDLE;
            div_reg <= '0;
            ph_reg <= '0;
            sh_reg <= '0;
            bit_reg <= '0;
            step_reg <= '0;
            left_reg <= '0;
            scl_reg <= 1'b1;
            sda_reg <= 1'b1;
            nack_reg <= 1'b0;
            rv_reg <= 1'b0;
            rx_reg <= 1'b1;
            rd_reg <= '0;
        end else begin
            st_reg <= st_next;
            div_reg <= div_next;
            ph_reg <= ph_next;
            sh_reg <= sh_next;
            bit_reg <= bit_next;
            step_reg <= step_next;
            left_reg <= left_next;
            scl_reg <= scl_next;
            sda_reg <= sda_next;
            nack_reg <= nack_next;
            rv_reg <= rv_next;
            rx_reg <= rx_next;
            rd_reg <= rd_next;
        end
    end

    assign link.scl_m_oe_n = scl_reg;
    assign link.sda_m_oe_n = sda_reg;
    assign cmd_busy = (st_reg != M_IDLE);
    assign cmd_nack = nack_reg;
    assign rd_valid = rv_reg;
    assign rd_data = rd_reg;
endmodule

/* File: src/twi_pkg.sv */
// shared constants and types for the two-wire register link
package twi_pkg;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 4;
    localparam int BIT_CNT_W = 4;
    localparam logic [BIT_CNT_W-1:0] LAST_BIT = 4'h7;
    localparam logic [6:0] ADDR_BASE = 7'h6a;
    localparam logic [7:0] REG_PTR_RST = 8'h00;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam int REG_COUNT = 256;
    localparam real MCLK_NS = 4.0;
    localparam real LINK_HALF_NS = 32.0;
    localparam int HALF_CYC = (int'(LINK_HALF_NS / MCLK_NS) < 1) ? 1
        : int'(LINK_HALF_NS / MCLK_NS);
    localparam logic [7:0] HALF_CYC_W = 8'(HALF_CYC);
    typedef enum logic [3:0] {
        S_IDLE = 4'h0, S_ADDR = 4'h1, S_ADDR_ACK = 4'h3, S_PTR = 4'h2,
        S_PTR_ACK = 4'h6, S_WDATA = 4'h7, S_WACK = 4'h5, S_RDATA = 4'h4,
        S_RACK = 4'hc
    } slave_state_t;
    typedef enum logic [3:0] {
        M_IDLE = 4'h0, M_START = 4'h1, M_BIT = 4'h3, M_ACK = 4'h2,
        M_RSTART = 4'h6, M_STOP = 4'h7, M_DONE = 4'h5
    } master_state_t;
endpackage

/* File: src/twi_link_if.sv */
// two-wire link carrier with wired-and resolution of both lines
`timescale 1ns/1ps
interface twi_link_if;
    logic scl_m_oe_n;
    logic sda_m_oe_n;
    logic scl_s_oe_n;
    logic sda_s_oe_n;
    wire scl = scl_m_oe_n & scl_s_oe_n;
    wire sda = sda_m_oe_n & sda_s_oe_n;
    modport device (input scl, input sda, output scl_s_oe_n, output sda_s_oe_n);
    modport host (input scl, input sda, output scl_m_oe_n, output sda_m_oe_n);
endinterface

/* File: src/byte_fifo.sv */
// small valid/ready fifo, width and depth parameters
`timescale 1ns/1ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic push, pop;

    // pointer and count updates
    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wr_next = push ? AW'(wr_reg + 1'b1) : wr_reg;
        rd_next = pop ? AW'(rd_reg + 1'b1) : rd_reg;
        cnt_next = cnt_reg;
        if (push && !pop) begin
            cnt_next = (AW+1)'(cnt_reg + 1'b1);
        end else if (pop && !push) begin
            cnt_next = (AW+1)'(cnt_reg - 1'b1);
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            cnt_reg <= cnt_next;
        end
    end

    // storage has no reset, data only
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end

    assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data = mem[rd_reg];
endmodule

/* File: src/twi_reg_slave.sv */
// register slave end of the two-wire link, oversampling scl and sda
`timescale 1ns/1ps
module twi_reg_slave (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // straps and standby
    input wire logic [1:0] addr_strap_pins,
    input wire logic standby_n,
    // link
    twi_link_if.device link,
    // observation of the register file
    output logic [7:0] wr_addr,
    output logic [7:0] wr_data,
    output logic wr_strobe,
    output logic busy
);
    import twi_pkg::*;

    logic [7:0] regs [REG_COUNT];
    logic scl_m, scl_s, sda_m, sda_s, scl_d, sda_d, sby_m, sby_s;
    logic [1:0] strap_m, strap_s;
    logic scl_rise, scl_fall, start_det, stop_det;
    slave_state_t st_reg, st_next;
    logic [BIT_CNT_W-1:0] bit_reg, bit_next;
    logic [7:0] sh_reg, sh_next, ptr_reg, ptr_next;
    logic sda_oe_n_reg, sda_oe_n_next;
    logic rw_reg, rw_next, wr_en;
    logic [6:0] my_addr;
    logic [7:0] wa_reg, wd_reg;
    logic ws_reg, busy_reg;

    // two-flop synchronisers for the pins
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            {scl_m, scl_s, sda_m, sda_s, sby_m, sby_s} <= 6'h3f;
            {scl_d, sda_d} <= 2'h3;
            strap_m <= 2'h0;
            strap_s <= 2'h0;
        end else begin
            scl_m <= link.scl;
            scl_s <= scl_m;
            sda_m <= link.sda;
            sda_s <= sda_m;
            sby_m <= standby_n;
            sby_s <= sby_m;
            strap_m <= addr_strap_pins;
            strap_s <= strap_m;
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    // edge and condition detection
    always_comb begin
        // base has bit 1 set, so straps must add rather than merge bitwise
        my_addr = ADDR_BASE + {5'h00, strap_s};
        scl_rise = scl_s && !scl_d;
        scl_fall = !scl_s && scl_d;
        start_det = scl_s && scl_d && sda_d && !sda_s;
        stop_det = scl_s && scl_d && !sda_d && sda_s;
    end

    // protocol state machine; the register-pointer survives restarts
    always_comb begin
        st_next = st_reg;
        bit_next = bit_reg;
        sh_next = sh_reg;
        ptr_next = ptr_reg;
        sda_oe_n_next = sda_oe_n_reg;
        rw_next = rw_reg;
        wr_en = 1'b0;
        if (!sby_s) begin
            st_next = S_IDLE;
            sda_oe_n_next = 1'b1;
        end else if (start_det) begin
            st_next = S_ADDR;
            bit_next = '0;
            sda_oe_n_next = 1'b1;
        end else if (stop_det) begin
            st_next = S_IDLE;
            sda_oe_n_next = 1'b1;
        end else begin
            case (st_reg)
                S_ADDR, S_PTR, S_WDATA: begin
                    if (scl_rise) begin
                        sh_next = {sh_reg[6:0], sda_s};
                        bit_next = BIT_CNT_W'(bit_reg + 1'b1);
                    end else if (scl_fall && bit_reg == 4'h8) begin
                        bit_next = '0;
                        if (st_reg == S_ADDR) begin
                            if (sh_reg[7:1] == my_addr) begin
                                sda_oe_n_next = 1'b0;
                                rw_next = sh_reg[0];
                                st_next = S_ADDR_ACK;
                            end else begin
                                st_next = S_IDLE;
                            end
                        end else if (st_reg == S_PTR) begin
                            ptr_next = sh_reg;
                            sda_oe_n_next = 1'b0;
                            st_next = S_PTR_ACK;
                        end else begin
                            wr_en = 1'b1;
                            sda_oe_n_next = 1'b0;
                            st_next = S_WACK;
                        end
                    end
                end
                S_ADDR_ACK, S_PTR_ACK, S_WACK: begin
                    // release only after the ninth clock falls
                    if (scl_fall) begin
                        sda_oe_n_next = 1'b1;
                        if (st_reg == S_WACK) begin
                            ptr_next = 8'(ptr_reg + 1'b1);
                        end
                        if (st_reg == S_ADDR_ACK && rw_reg) begin
                            st_next = S_RDATA;
                            sda_oe_n_next = regs[ptr_reg][7];
                            bit_next = 4'h1;
                            sh_next = {regs[ptr_reg][6:0], 1'b0};
                        end else begin
                            st_next = (st_reg == S_ADDR_ACK) ? S_PTR : S_WDATA;
                        end
                    end
                end
                S_RDATA: begin
                    // data driven on falling scl only
                    if (scl_fall) begin
                        if (bit_reg == 4'h8) begin
                            sda_oe_n_next = 1'b1;
                            ptr_next = 8'(ptr_reg + 1'b1);
                            st_next = S_RACK;
                        end else begin
                            sda_oe_n_next = sh_reg[7];
                            sh_next = {sh_reg[6:0], 1'b0};
                            bit_next = BIT_CNT_W'(bit_reg + 1'b1);
                        end
                    end
                end
                S_RACK: begin
                    if (scl_rise) begin
                        rw_next = sda_s; // nack ends the read
                    end else if (scl_fall) begin
                        if (rw_reg) begin
                            st_next = S_IDLE;
                        end else begin
                            rw_next = 1'b1;
                            st_next = S_RDATA;
                            sda_oe_n_next = regs[ptr_reg][7];
                            bit_next = 4'h1;
                            sh_next = {regs[ptr_reg][6:0], 1'b0};
                        end
                    end
                end
                default: st_next = S_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= S_IDLE;
            bit_reg <= '0;
            sh_reg <= '0;
            ptr_reg <= REG_PTR_RST;
            sda_oe_n_reg <= 1'b1;
            rw_reg <= 1'b0;
            wa_reg <= '0;
            wd_reg <= '0;
            ws_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            bit_reg <= bit_next;
            sh_reg <= sh_next;
            ptr_reg <= ptr_next;
            sda_oe_n_reg <= sda_oe_n_next;
            rw_reg <= rw_next;
            ws_reg <= wr_en;
            busy_reg <= (st_next != S_IDLE);
            if (wr_en) begin
                wa_reg <= ptr_reg;
                wd_reg <= sh_reg;
            end
        end
    end

    // register file, cleared by reset
    genvar gi;
    generate
        for (gi = 0; gi < REG_COUNT; gi++) begin : g_reg
            always_ff @(posedge mclk or negedge rstn) begin
                if (!rstn) begin
                    regs[gi] <= REG_RST;
                end else if (wr_en && ptr_reg == 8'(gi)) begin
                    regs[gi] <= sh_reg;
                end
            end
        end
    endgenerate

    assign link.scl_s_oe_n = 1'b1;
    assign link.sda_s_oe_n = sda_oe_n_reg;
    assign wr_addr = wa_reg;
    assign wr_data = wd_reg;
    assign wr_strobe = ws_reg;
    assign busy = busy_reg;
endmodule

/* File: dv/twi_link_props.sv */
// line-level assertions for the two-wire link between host and register slave
`timescale 1ns/1ps
module twi_link_props (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // resolved lines
    input wire logic scl,
    input wire logic sda,
    // per-party enables, low pulls the line
    input wire logic scl_m_oe_n,
    input wire logic sda_m_oe_n,
    input wire logic scl_s_oe_n,
    input wire logic sda_s_oe_n
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    // slave never stretches the clock
    a_slave_no_stretch: assert property (scl_s_oe_n)
        else $error("slave pulled the clock line");
    // both ends come out of reset with the lines released
    a_reset_lines_free: assert property ($rose(rstn) |->
        scl_m_oe_n && sda_m_oe_n && sda_s_oe_n)
        else $error("line driven at reset release");
    // slave data only moves while the clock is low
    a_slave_data_stable: assert property (scl && $past(scl) |-> $stable(sda_s_oe_n))
        else $error("slave moved data while clock high");
    // a low bit from the slave lasts at least eight cycles after the clock rises
    a_ack_held: assert property ($rose(scl) && !sda_s_oe_n |-> !sda_s_oe_n [*8])
        else $error("slave released data during high phase");
    // high phase no shorter than the chosen bit timing allows
    a_scl_high_min: assert property ($rose(scl) |-> scl [*8])
        else $error("clock high phase too short");
    // low phase is bounded, so transfers keep their rate
    a_scl_low_max: assert property ($fell(scl) |-> ##[1:60] scl)
        else $error("clock held low too long");
    // a start is followed by clocking of the address byte
    a_start_clocks: assert property (scl && $fell(sda) |-> ##[1:60] !scl)
        else $error("no clock after start");
    // for four cycles after a stop the slave keeps off the data line
    a_stop_slave_quiet: assert property (scl && $rose(sda) |=> sda_s_oe_n [*4])
        else $error("slave drove data after stop");

    // main scenarios
    cover property (scl && $fell(sda));
    cover property ($rose(scl) && !sda_s_oe_n);
    cover property (scl && $rose(sda));
endmodule

/* File: dv/tb_twi_reg_slave.sv */
// self-checking bench: host end and register slave joined over the link
`timescale 1ns/1ps
module tb_twi_reg_slave;
    import twi_pkg::*;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [1:0] addr_strap_pins = 2'h0;
    logic standby_n = 1'b1;
    logic cmd_go = 1'b0;
    logic [6:0] cmd_dev = 7'h00;
    logic [7:0] cmd_ptr = 8'h00;
    logic [7:0] cmd_rd_len = 8'h00;
    logic wd_valid = 1'b0;
    logic [7:0] wd_data = 8'h00;
    logic cmd_busy, cmd_nack, wd_ready, rd_valid, wr_strobe, busy;
    logic [7:0] rd_data, wr_addr, wr_data;
    logic [15:0] wq[$];
    logic [7:0] rq[$];
    logic [7:0] shadow [0:255];
    logic [31:0] seed = 32'd14661;
    // strap-selected write address bytes, strap value as index
    logic [7:0] wr_byte [4] = '{8'hd4, 8'hd6, 8'hd8, 8'hda};
    logic busy_seen = 1'b0;
    int errors = 0;
    int cmp_count = 0;
    int cycles = 0;

    always #2 mclk = ~mclk;

    twi_link_if link ();
    twi_reg_slave twi_reg_slave_inst (.mclk(mclk), .rstn(rstn),
        .addr_strap_pins(addr_strap_pins), .standby_n(standby_n), .link(link.device),
        .wr_addr(wr_addr), .wr_data(wr_data), .wr_strobe(wr_strobe), .busy(busy));
    twi_host twi_host_inst (.mclk(mclk), .rstn(rstn), .cmd_go(cmd_go), .cmd_dev(cmd_dev),
        .cmd_ptr(cmd_ptr), .cmd_rd_len(cmd_rd_len), .cmd_busy(cmd_busy),
        .cmd_nack(cmd_nack), .wd_valid(wd_valid), .wd_ready(wd_ready), .wd_data(wd_data),
        .rd_valid(rd_valid), .rd_data(rd_data), .link(link.host));
    twi_link_props twi_link_props_inst (.mclk(mclk), .rstn(rstn), .scl(link.scl),
        .sda(link.sda), .scl_m_oe_n(link.scl_m_oe_n), .sda_m_oe_n(link.sda_m_oe_n),
        .scl_s_oe_n(link.scl_s_oe_n), .sda_s_oe_n(link.sda_s_oe_n));

    function automatic logic [7:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        if (errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // fill side: hold valid until the fifo takes the byte, note the expected store
    task automatic push(input logic [7:0] ptr, input logic [7:0] d);
        @(posedge mclk);
        #1;
        wd_valid = 1'b1;
        wd_data = d;
        @(posedge mclk);
        while (wd_ready !== 1'b1) @(posedge mclk);
        #1;
        wd_valid = 1'b0;
        wq.push_back({ptr, d});
        shadow[ptr] = d;
    endtask

    // one command, then a bounded wait for the host to go idle
    task automatic run(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] len);
        int n;
        @(posedge mclk);
        #1;
        cmd_dev = dev;
        cmd_ptr = ptr;
        cmd_rd_len = len;
        cmd_go = 1'b1;
        @(posedge mclk);
        #1;
        cmd_go = 1'b0;
        n = 0;
        busy_seen = 1'b0;
        while (cmd_busy !== 1'b0 && n < 20000) begin
            @(posedge mclk);
            #1;
            busy_seen = busy_seen | busy;
            n++;
        end
        if (n >= 20000) errors++;
        check({15'h0000, busy}, 16'h0000);
    endtask

    // expected read-back, one byte more than written to cover untouched places
    task automatic read_back(input logic [6:0] dev, input logic [7:0] ptr, input int len);
        for (int i = 0; i < len; i++) rq.push_back(shadow[8'(ptr + i)]);
        run(dev, ptr, 8'(len));
        check({15'h0000, cmd_nack}, 16'h0000);
    endtask

    // result watcher: every store and every returned byte retires the oldest note
    always @(posedge mclk) begin
        cycles++;
        if (wr_strobe === 1'b1) begin
            check({wr_addr, wr_data}, (wq.size() > 0) ? wq.pop_front() : 16'hxxxx);
        end
        if (rd_valid === 1'b1) begin
            check({8'h00, rd_data}, (rq.size() > 0) ? {8'h00, rq.pop_front()} : 16'hxxxx);
        end
        if (cycles == 60000) begin
            errors++;
            wrap_up();
        end
    end

    initial begin
        logic [7:0] p;
        for (int i = 0; i < 256; i++) shadow[i] = REG_RST;
        repeat (8) @(posedge mclk);
        #1;
        rstn = 1'b1;
        // every strap setting: random write of four bytes, then read back five
        for (int s = 0; s < 4; s++) begin
            addr_strap_pins = 2'(s);
            p = (s == 3) ? 8'hfd : xs();
            for (int i = 0; i < 4; i++) push(8'(p + i), xs());
            check({15'h0000, wd_ready}, 16'h0000);
            run(wr_byte[s][7:1], p, 8'h00);
            check({15'h0000, cmd_nack}, 16'h0000);
            check({15'h0000, busy_seen}, 16'h0001);
            read_back(wr_byte[s][7:1], p, 5);
        end
        // neighbour's address is not answered
        run(wr_byte[2][7:1], 8'h10, 8'h00);
        check({15'h0000, cmd_nack}, 16'h0001);
        // standby: own address is ignored too
        standby_n = 1'b0;
        run(wr_byte[3][7:1], 8'h10, 8'h01);
        check({15'h0000, cmd_nack}, 16'h0001);
        check({15'h0000, busy_seen}, 16'h0000);
        standby_n = 1'b1;
        rq.delete();
        // long write across the pointer wrap, refilling the fifo while it drains
        for (int i = 0; i < 4; i++) push(8'(8'hfa + i), xs());
        fork
            run(wr_byte[3][7:1], 8'hfa, 8'h00);
            for (int i = 4; i < 10; i++) push(8'(8'hfa + i), xs());
        join
        read_back(wr_byte[3][7:1], 8'hfa, 11);
        repeat (20) @(posedge mclk);
        check(16'(wq.size() + rq.size()), 16'h0000);
        wrap_up();
    end
endmodule
